// ---- logic/midr_core.sv ----
// instruction decode and read-modify-write execution core
// assumes program memory answers instrWord for pcOut by the fetch edge,
// and the file register array answers fileRdData in the cycle of fileRdEn
// Function
// - file operands always read before written
// - destination bit picks working or file
// - file address field is seven bits
// - bit field picks one of eight bits
// - don't care bits never change decoding
// - or, and, xor with file touch zero
// - rotates go through carry, change carry only
// - increment/decrement skip forms skip next when result zero
// - bit tests skip on clear or set
// - literal or, and, xor update zero only
// - literal add and subtract update three flags
// - return with literal loads working, pops
// - standby enters sleep, updates status bits
// - branches and true tests take two cycles
// - port rewrite uses pin levels, not latch
// - timer zero write clears assigned prescaler
// - port read clears the change mismatch
// - instruction cycle is four clock periods
// - literals are eight bits, targets eleven
//
// Chosen here: strobed register access and the register offsets.
module midr_core
  import midr_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               resetn,
  input  wire logic [INSTR_W-1:0] instrWord,
  output logic [PC_W-1:0]         pcOut,
  output logic [FADDR_W-1:0]      fileAddr,
  output logic                    fileRdEn,
  input  wire logic [DATA_W-1:0]  fileRdData,
  output logic                    fileWrEn,
  output logic [DATA_W-1:0]       fileWrData,
  input  wire logic [DATA_W-1:0]  portPins,
  output logic                    portMismatchClr,
  output logic                    prescalerClr,
  output logic                    wdtClr,
  output logic                    sleepEnter,
  input  wire midr_regbus_t       regBus,
  output logic [31:0]             regRdData
);

  midr_state_t q;
  midr_state_t d;
  midr_dec_t   dec;
  logic [7:0]  aluRes;
  logic        aluC;
  logic        aluDc;
  logic        aluZ;
  logic        skipNow;
  logic        writeAdv;
  logic [PC_W-1:0] nextPc;

  function automatic midr_dec_t decode(input logic [INSTR_W-1:0] w);
    midr_dec_t r;
    r       = '0;
    r.aluOp = ALU_PASSA;
    casez (w[13:8])
      6'b00_0000: begin
        if (w[7]) begin
          r.aluOp   = ALU_PASSB;
          r.useFile = 1'b1;
          r.wrFile  = 1'b1;
        end else begin
          r.isSleep = (w[7:0] == SLEEP_LO);
          r.isWdt   = (w[7:0] == CLRWDT_LO);
          r.isRet   = (w[7:0] == RETURN_LO) || (w[7:0] == RETINT_LO);
        end
      end
      6'b00_0001: begin
        r.aluOp   = ALU_CLR;
        r.useFile = w[7];
        r.wrFile  = w[7];
        r.wrW     = ~w[7];
        r.updZ    = 1'b1;
      end
      6'b00_????: begin
        r.useFile = 1'b1;
        r.wrFile  = w[7];
        r.wrW     = ~w[7];
        case (w[11:8])
          4'h2: r.aluOp = ALU_SUB;
          4'h3: r.aluOp = ALU_DEC;
          4'h4: r.aluOp = ALU_IOR;
          4'h5: r.aluOp = ALU_AND;
          4'h6: r.aluOp = ALU_XOR;
          4'h7: r.aluOp = ALU_ADD;
          4'h8: r.aluOp = ALU_PASSA;
          4'h9: r.aluOp = ALU_COM;
          4'ha: r.aluOp = ALU_INC;
          4'hb: r.aluOp = ALU_DEC;
          4'hc: r.aluOp = ALU_RRC;
          4'hd: r.aluOp = ALU_RLC;
          4'he: r.aluOp = ALU_SWAP;
          default: r.aluOp = ALU_INC;
        endcase
        r.skipZero = (w[11:8] == 4'hb) || (w[11:8] == 4'hf);
        r.updC     = (w[11:8] == 4'h2) || (w[11:8] == 4'h7)
                     || (w[11:8] == 4'hc) || (w[11:8] == 4'hd);
        r.updDc    = (w[11:8] == 4'h2) || (w[11:8] == 4'h7);
        r.updZ     = !r.skipZero && (w[11:8] != 4'he)
                     && (w[11:8] != 4'hc) && (w[11:8] != 4'hd);
      end
      6'b01_????: begin
        r.useFile = 1'b1;
        r.aluOp   = w[10] ? ALU_BSET : ALU_BCLR;
        r.wrFile  = ~w[11];
        r.bitTest = w[11];
        r.skipSet = w[10];
      end
      6'b10_????: begin
        r.isCall = ~w[11];
        r.isJump = w[11];
      end
      6'b11_00??: r.wrW = 1'b1;
      6'b11_01??: begin
        r.wrW   = 1'b1;
        r.isRet = 1'b1;
      end
      6'b11_1000: begin
        r.aluOp = ALU_IOR;
        r.wrW   = 1'b1;
        r.updZ  = 1'b1;
      end
      6'b11_1001: begin
        r.aluOp = ALU_AND;
        r.wrW   = 1'b1;
        r.updZ  = 1'b1;
      end
      6'b11_1010: begin
        r.aluOp = ALU_XOR;
        r.wrW   = 1'b1;
        r.updZ  = 1'b1;
      end
      6'b11_11??: begin
        r.aluOp = w[9] ? ALU_ADD : ALU_SUB;
        r.wrW   = 1'b1;
        r.updZ  = 1'b1;
        r.updC  = 1'b1;
        r.updDc = 1'b1;
      end
      default: r.aluOp = ALU_PASSA;
    endcase
    return r;
  endfunction : decode

  assign dec = decode(q.instr);

  midr_alu u_alu (
    .op      (dec.aluOp),
    .a       (q.opnd),
    .b       (q.wreg),
    .bitSel  (q.instr[9:7]),
    .carryIn (q.cFlag),
    .res     (aluRes),
    .cOut    (aluC),
    .dcOut   (aluDc),
    .zOut    (aluZ)
  );

  assign skipNow  = (dec.skipZero && q.resZ)
                    || (dec.bitTest && (q.opnd[q.instr[9:7]] == dec.skipSet));
  assign writeAdv = (q.phase == PH_WRITE) && q.adv;
  assign nextPc   = q.pc + 13'h0001;

  always_comb begin
    d          = q;
    d.pinMeta  = portPins;
    d.pinSync  = q.pinMeta;
    d.phase    = q.phase + 2'h1;
    d.rdData   = 32'h0000_0000;
    if (regBus.rd) begin
      case (regBus.addr)
        REG_CTRL: d.rdData = {30'h0000_0000, q.ctrl};
        REG_STAT: d.rdData = {26'h000_0000, q.sleeping, q.toBit, q.pdBit,
                              q.zFlag, q.dcFlag, q.cFlag};
        REG_WREG: d.rdData = {24'h00_0000, q.wreg};
        default:  d.rdData = 32'h0000_0000;
      endcase
    end
    if (regBus.wr && (regBus.addr == REG_CTRL)) begin
      d.ctrl = regBus.wrData[1:0];
    end
    case (q.phase)
      PH_FETCH: begin
        // a flushed slot runs as a no-operation and does not advance the counter
        d.adv   = q.ctrl[CTRL_RUN_BIT] && !q.sleeping && !q.flush;
        d.instr = d.adv ? instrWord : NOP_WORD;
        d.flush = 1'b0;
      end
      PH_READ: begin
        if (dec.useFile) begin
          // port reads see the pins, so inputs pulled low write back as zero
          d.opnd = (q.instr[6:0] == ADDR_PORT) ? q.pinSync : fileRdData;
        end else begin
          d.opnd = q.instr[7:0];
        end
      end
      PH_EXEC: begin
        d.res   = aluRes;
        d.resC  = aluC;
        d.resDc = aluDc;
        d.resZ  = aluZ;
      end
      PH_WRITE: begin
        if (q.adv) begin
          d.pc = nextPc;
          if (dec.wrW) begin
            d.wreg = q.res;
          end
          if (dec.updZ) begin
            d.zFlag = q.resZ;
          end
          if (dec.updC) begin
            d.cFlag = q.resC;
          end
          if (dec.updDc) begin
            d.dcFlag = q.resDc;
          end
          if (skipNow) begin
            // the flushed slot replaces the skipped word, so step past it here
            d.pc    = q.pc + 13'h0002;
            d.flush = 1'b1;
          end
          if (dec.isCall || dec.isJump) begin
            d.pc    = {q.pc[PC_W-1:TGT_W], q.instr[TGT_W-1:0]};
            d.flush = 1'b1;
          end
          if (dec.isCall) begin
            // circular stack: overflow silently drops the oldest entry
            d.stack[q.sp] = nextPc;
            d.sp          = q.sp + 3'h1;
          end
          if (dec.isRet) begin
            d.sp    = q.sp - 3'h1;
            d.pc    = q.stack[q.sp - 3'h1];
            d.flush = 1'b1;
          end
          if (dec.isSleep) begin
            d.sleeping = 1'b1;
            d.pdBit    = 1'b0;
            d.toBit    = 1'b1;
          end
          if (dec.isWdt) begin
            d.pdBit = 1'b1;
            d.toBit = 1'b1;
          end
        end
      end
      default: d.phase = PH_FETCH;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      q       <= '0;
      q.pc    <= PC_RESET;
      q.wreg  <= W_RESET;
      q.instr <= NOP_WORD;
      q.toBit <= 1'b1;
      q.pdBit <= 1'b1;
      q.ctrl  <= CTRL_RESET;
    end else begin
      q <= d;
    end
  end

  assign pcOut           = q.pc;
  assign fileAddr        = q.instr[FADDR_W-1:0];
  assign fileRdEn        = (q.phase == PH_READ) && dec.useFile;
  assign fileWrEn        = (q.phase == PH_WRITE) && q.adv && dec.wrFile;
  assign fileWrData      = q.res;
  assign portMismatchClr = fileRdEn && (fileAddr == ADDR_PORT);
  assign prescalerClr    = fileWrEn && (fileAddr == ADDR_TIMER_ZERO)
                           && q.ctrl[CTRL_PSA_BIT];
  assign wdtClr          = writeAdv && dec.isWdt;
  assign sleepEnter      = writeAdv && dec.isSleep;
  assign regRdData       = q.rdData;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  property p_rmw_read_first;
    fileWrEn |-> $past(fileRdEn, 2) && ($past(fileAddr, 2) == fileAddr);
  endproperty
  a_rmw_read_first: assert property (p_rmw_read_first)
    else $error("file write without read");
  property p_dest_w;
    writeAdv && (q.instr[13:12] == CLS_BYTE) && (q.instr[11:9] != 3'h0) && !q.instr[7]
      |-> !fileWrEn ##1 (q.wreg == $past(q.res));
  endproperty
  a_dest_w: assert property (p_dest_w)
    else $error("d=0 result not in working register");
  property p_cycle_four;
    fileRdEn |=> !fileRdEn [*3];
  endproperty
  a_cycle_four: assert property (p_cycle_four)
    else $error("instruction cycle not four clocks");
  property p_logic_zero_only;
    writeAdv && (q.instr[13:10] == 4'h1) && (q.instr[9:8] != 2'h3)
      |=> $stable(q.cFlag) && $stable(q.dcFlag) && (q.zFlag == $past(q.resZ));
  endproperty
  a_logic_zero_only: assert property (p_logic_zero_only)
    else $error("logic op flag error");
  property p_skip;
    writeAdv && skipNow |=> q.flush && (q.pc == $past(q.pc) + 13'h0002);
  endproperty
  a_skip: assert property (p_skip)
    else $error("skip did not step two words");
  property p_flush_nop;
    (q.phase == PH_FETCH) && q.flush |=> !q.adv [*4];
  endproperty
  a_flush_nop: assert property (p_flush_nop)
    else $error("second cycle not a no-operation");
  property p_call;
    writeAdv && dec.isCall
      |=> (q.pc[TGT_W-1:0] == $past(q.instr[TGT_W-1:0])) && (q.sp == $past(q.sp) + 3'h1);
  endproperty
  a_call: assert property (p_call)
    else $error("call target or push wrong");
  property p_ret_literal;
    writeAdv && (q.instr[13:10] == 4'hd) |=> (q.wreg == $past(q.instr[7:0])) && q.flush;
  endproperty
  a_ret_literal: assert property (p_ret_literal)
    else $error("return literal not loaded");
  property p_sleep;
    sleepEnter |=> q.sleeping && !q.pdBit && q.toBit ##4 !q.adv;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("standby status wrong");
  property p_port_pins;
    fileRdEn && (fileAddr == ADDR_PORT)
      |=> (q.opnd == $past(q.pinSync)) && portMismatchClr == 1'b0;
  endproperty
  a_port_pins: assert property (p_port_pins)
    else $error("port operand not from pins");
  // judged from the instruction word, so a wrong file-write decode is caught too
  property p_prescaler;
    writeAdv && (q.instr[13:12] == CLS_BYTE) && (q.instr[6:0] == ADDR_TIMER_ZERO)
      |-> (prescalerClr == (q.instr[7] && q.ctrl[CTRL_PSA_BIT]));
  endproperty
  a_prescaler: assert property (p_prescaler)
    else $error("prescaler clear does not follow destination");
  property p_port_clear_read;
    (q.phase == PH_READ) && (q.instr[6:0] == ADDR_PORT)
      && (((q.instr[13:12] == CLS_BYTE) && q.instr[7]) || (q.instr[13:12] == CLS_BIT))
      |-> portMismatchClr;
  endproperty
  a_port_clear_read: assert property (p_port_clear_read)
    else $error("port read missed mismatch clear");

  c_call:  cover property (writeAdv && dec.isCall);
  c_skip:  cover property (writeAdv && skipNow);
  c_sleep: cover property (sleepEnter);
  c_tmr:   cover property (prescalerClr);

endmodule : midr_core

// ---- logic/midr_pkg.sv ----
// shared constants, opcodes, carriers and state layout for the instruction decoder core
// assumes one 100 MHz ref_clk; four ref_clk periods form one instruction cycle
package midr_pkg;

  localparam int INSTR_W       = 14;
  localparam int PC_W          = 13;
  localparam int DATA_W        = 8;
  localparam int FADDR_W       = 7;
  localparam int TGT_W         = 11;
  localparam int STACK_D       = 8;
  localparam int SP_W          = 3;
  localparam int OSC_PER_CYCLE = 4;

  localparam logic [1:0] PH_FETCH = 2'h0;
  localparam logic [1:0] PH_READ  = 2'h1;
  localparam logic [1:0] PH_EXEC  = 2'h2;
  localparam logic [1:0] PH_WRITE = 2'h3;

  localparam logic [1:0] CLS_BYTE = 2'h0;
  localparam logic [1:0] CLS_BIT  = 2'h1;

  localparam logic [FADDR_W-1:0] ADDR_TIMER_ZERO = 7'h01;
  localparam logic [FADDR_W-1:0] ADDR_PORT       = 7'h05;

  localparam logic [INSTR_W-1:0] NOP_WORD   = 14'h0000;
  localparam logic [7:0]         SLEEP_LO   = 8'h63;
  localparam logic [7:0]         CLRWDT_LO  = 8'h64;
  localparam logic [7:0]         RETURN_LO  = 8'h08;
  localparam logic [7:0]         RETINT_LO  = 8'h09;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_WREG = 8'h08;

  localparam int         CTRL_PSA_BIT = 0;
  localparam int         CTRL_RUN_BIT = 1;
  localparam logic [1:0] CTRL_RESET   = 2'h2;

  localparam int STAT_C_BIT   = 0;
  localparam int STAT_DC_BIT  = 1;
  localparam int STAT_Z_BIT   = 2;
  localparam int STAT_PD_BIT  = 3;
  localparam int STAT_TO_BIT  = 4;
  localparam int STAT_SLP_BIT = 5;

  localparam logic [PC_W-1:0]   PC_RESET = 13'h0000;
  localparam logic [DATA_W-1:0] W_RESET  = 8'h00;

  typedef enum logic [3:0] {
    ALU_PASSA = 4'h0, ALU_PASSB = 4'h1, ALU_ADD  = 4'h2, ALU_SUB  = 4'h3,
    ALU_AND   = 4'h4, ALU_IOR   = 4'h5, ALU_XOR  = 4'h6, ALU_CLR  = 4'h7,
    ALU_COM   = 4'h8, ALU_INC   = 4'h9, ALU_DEC  = 4'ha, ALU_RLC  = 4'hb,
    ALU_RRC   = 4'hc, ALU_SWAP  = 4'hd, ALU_BCLR = 4'he, ALU_BSET = 4'hf
  } midr_alu_op_t;

  typedef struct packed {
    midr_alu_op_t aluOp;
    logic useFile;
    logic wrFile;
    logic wrW;
    logic updZ;
    logic updC;
    logic updDc;
    logic skipZero;
    logic bitTest;
    logic skipSet;
    logic isCall;
    logic isJump;
    logic isRet;
    logic isSleep;
    logic isWdt;
  } midr_dec_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wrData;
    logic        wr;
    logic        rd;
  } midr_regbus_t;

  typedef struct packed {
    logic [1:0]                      phase;
    logic                            adv;
    logic                            flush;
    logic [INSTR_W-1:0]              instr;
    logic [PC_W-1:0]                 pc;
    logic [STACK_D-1:0][PC_W-1:0]    stack;
    logic [SP_W-1:0]                 sp;
    logic [DATA_W-1:0]               wreg;
    logic                            cFlag;
    logic                            dcFlag;
    logic                            zFlag;
    logic                            toBit;
    logic                            pdBit;
    logic                            sleeping;
    logic [DATA_W-1:0]               opnd;
    logic [DATA_W-1:0]               res;
    logic                            resC;
    logic                            resDc;
    logic                            resZ;
    logic [1:0]                      ctrl;
    logic [31:0]                     rdData;
    logic [DATA_W-1:0]               pinMeta;
    logic [DATA_W-1:0]               pinSync;
  } midr_state_t;

endpackage : midr_pkg

// ---- logic/midr_alu.sv ----
// eight-bit arithmetic and logic unit of the decoder core
// assumes the caller latches the outputs; purely combinational
module midr_alu
  import midr_pkg::*;
(
  input  wire midr_alu_op_t op,
  input  wire logic [7:0]   a,
  input  wire logic [7:0]   b,
  input  wire logic [2:0]   bitSel,
  input  wire logic         carryIn,
  output logic [7:0]        res,
  output logic              cOut,
  output logic              dcOut,
  output logic              zOut
);

  always_comb begin
    logic [8:0] sum;
    logic [4:0] nib;
    sum   = 9'h000;
    nib   = 5'h00;
    res   = a;
    cOut  = carryIn;
    dcOut = 1'b0;
    case (op)
      ALU_ADD: begin
        sum   = {1'b0, a} + {1'b0, b};
        nib   = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        res   = sum[7:0];
        cOut  = sum[8];
        dcOut = nib[4];
      end
      ALU_SUB: begin
        // carry set means no borrow
        sum   = {1'b0, a} + {1'b0, ~b} + 9'h001;
        nib   = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
        res   = sum[7:0];
        cOut  = sum[8];
        dcOut = nib[4];
      end
      ALU_PASSA: res = a;
      ALU_PASSB: res = b;
      ALU_AND:   res = a & b;
      ALU_IOR:   res = a | b;
      ALU_XOR:   res = a ^ b;
      ALU_CLR:   res = 8'h00;
      ALU_COM:   res = ~a;
      ALU_INC:   res = a + 8'h01;
      ALU_DEC:   res = a - 8'h01;
      ALU_RLC: begin
        res  = {a[6:0], carryIn};
        cOut = a[7];
      end
      ALU_RRC: begin
        res  = {carryIn, a[7:1]};
        cOut = a[0];
      end
      ALU_SWAP:  res = {a[3:0], a[7:4]};
      ALU_BCLR:  res = a & ~(8'h01 << bitSel);
      ALU_BSET:  res = a | (8'h01 << bitSel);
      default:   res = a;
    endcase
    zOut = (res == 8'h00);
  end

endmodule : midr_alu

// ---- test/midr_prog_mem.sv ----
// program memory model that answers the core's fetch address
// assumes the bench fills mem before reset is released; empty words read as no-op
module midr_prog_mem
  import midr_pkg::*;
(
  input  wire logic [PC_W-1:0] pc,
  output logic [INSTR_W-1:0]   word
);
  logic [INSTR_W-1:0] mem [0:(1<<PC_W)-1];

  // unwritten words fetch as no-op, so a runaway pc shows as missing writes
  initial begin
    for (int i = 0; i < (1 << PC_W); i++) begin
      mem[i] = NOP_WORD;
    end
  end

  // combinational read: the word for pc is settled well before the fetch edge
  assign word = mem[pc];
endmodule : midr_prog_mem

// ---- test/mcu_instruction_decode_rmw_tb.sv ----
// self-checking bench: runs one program through the core, checks file writes,
// their spacing and the register view after standby
// assumes midr_core fed by midr_prog_mem and a combinational file array here
module mcu_instruction_decode_rmw_tb
  import midr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
    logic [7:0] slot;
  } midr_wnote_t;

  logic               ref_clk, resetn, rdPend, sleepSeen;
  logic               fileRdEn, fileWrEn, portMismatchClr, prescalerClr, sleepEnter, wdtClr;
  logic [INSTR_W-1:0] instrWord;
  logic [PC_W-1:0]    pcOut;
  logic [FADDR_W-1:0] fileAddr, rdAddr;
  logic [DATA_W-1:0]  fileRdData, fileWrData, portPins;
  logic [DATA_W-1:0]  fileMem [0:127];
  logic [31:0]        regRdData, seed;
  midr_regbus_t       regBus;
  midr_wnote_t        e;
  midr_wnote_t        wq[$];
  logic [31:0]        rq[$];
  int                 cyc, base, rdCyc, mmCount, psCount, wdCount, failCount, checks;

  midr_prog_mem pmem (.pc(pcOut), .word(instrWord));

  midr_core dut (
    .ref_clk(ref_clk), .resetn(resetn), .instrWord(instrWord), .pcOut(pcOut),
    .fileAddr(fileAddr), .fileRdEn(fileRdEn), .fileRdData(fileRdData),
    .fileWrEn(fileWrEn), .fileWrData(fileWrData), .portPins(portPins),
    .portMismatchClr(portMismatchClr), .prescalerClr(prescalerClr), .wdtClr(wdtClr),
    .sleepEnter(sleepEnter), .regBus(regBus), .regRdData(regRdData)
  );

  // file array: read in the same cycle as the read strobe
  assign fileRdData = fileMem[fileAddr];

  always @(posedge ref_clk) begin
    if (fileWrEn === 1'b1) begin
      fileMem[fileAddr] <= fileWrData;
    end
  end

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return x[0] ? ((x >> 1) ^ 32'ha300_0000) : (x >> 1);
  endfunction : lfsr

  function automatic logic [13:0] w14(input logic [13:0] b, input logic [7:0] v);
    return b | {6'h00, v};
  endfunction : w14

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failCount++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic testDone();
    $display("checks %0d mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : testDone

  // one bus cycle; a read notes its expected answer first
  task automatic bus(input logic w, input logic r, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] x);
    regBus <= '{addr: a, wrData: d, wr: w, rd: r};
    if (r) begin
      rq.push_back(x);
    end
    @(posedge ref_clk);
  endtask : bus

  // watcher: takes the oldest note whenever a result shows
  always @(posedge ref_clk) begin
    cyc++;
    rdPend <= regBus.rd;
    if (rdPend === 1'b1) begin
      check(regRdData, rq.pop_front());
    end
    if (fileRdEn === 1'b1) begin
      rdAddr = fileAddr;
      rdCyc = cyc;
    end
    if (portMismatchClr === 1'b1) mmCount++;
    if (prescalerClr === 1'b1) psCount++;
    if (wdtClr === 1'b1) wdCount++;
    if (sleepEnter === 1'b1) begin
      sleepSeen = 1'b1;
      check(32'(cyc - base), 32'd100);
    end
    if (fileWrEn === 1'b1 && wq.size() == 0) begin
      check(32'h0, 32'h1);
    end else if (fileWrEn === 1'b1) begin
      e = wq.pop_front();
      if (e.slot == 8'd2) base = cyc;
      check({17'h0, fileAddr, fileWrData}, {17'h0, e.addr, e.data});
      check(32'(cyc - base), 32'(4 * (int'(e.slot) - 2)));
      check({rdAddr, 25'(cyc - rdCyc)}, {e.addr, 25'd2});
    end
  end

  initial begin : mainSeq
    logic [7:0]  k [1:7];
    logic [7:0]  w;
    logic [13:0] pw [0:21];
    logic        c, dc, z;
    resetn = 1'b0;
    regBus = '0;
    rdPend = 1'b0;
    sleepSeen = 1'b0;
    seed = 32'h099a_ebd0;
    for (int i = 0; i < 128; i++) begin
      seed = lfsr(seed);
      fileMem[i] = seed[7:0];
    end
    for (int i = 1; i < 8; i++) begin
      seed = lfsr(seed);
      k[i] = seed[7:0];
    end
    seed = lfsr(seed);
    portPins = seed[7:0];
    // decrement lands on zero, increment never wraps, tested bit is set
    fileMem[37] = 8'h01;
    fileMem[38][7] = 1'b0;
    fileMem[39][7] = 1'b1;
    #1;
    // 0x30ff words sit in skipped slots: running them would spoil the working register
    pw = '{w14(14'h3300, k[1]), 14'h04a0, 14'h0521, 14'h06a2, 14'h0da3, 14'h0ca4,
           14'h0485, 14'h0181, 14'h0ba5, 14'h30ff, 14'h0fa6, 14'h1fa7, 14'h30ff,
           14'h1ba7, w14(14'h3a00, k[2]), w14(14'h3900, k[3]), w14(14'h3800, k[4]),
    // the return lands on a clear-watchdog, then standby follows it
           w14(14'h3f00, k[5]), w14(14'h3d00, k[6]), 14'h2020, 14'h0064, 14'h0063};
    for (int i = 0; i < 22; i++) begin
      pmem.mem[i] = pw[i];
    end
    pmem.mem[32] = 14'h2822;
    pmem.mem[34] = w14(14'h3400, k[7]);
    // expected writes with their instruction slot
    wq.push_back('{7'h20, k[1] | fileMem[32], 8'd2});
    w = k[1] & fileMem[33];
    wq.push_back('{7'h22, w ^ fileMem[34], 8'd4});
    wq.push_back('{7'h23, {fileMem[35][6:0], 1'b0}, 8'd5});
    wq.push_back('{7'h24, {fileMem[35][7], fileMem[36][7:1]}, 8'd6});
    c = fileMem[36][0];
    wq.push_back('{7'h05, w | portPins, 8'd7});
    wq.push_back('{7'h01, 8'h00, 8'd8});
    wq.push_back('{7'h25, 8'h00, 8'd9});
    wq.push_back('{7'h26, fileMem[38] + 8'h01, 8'd11});
    w = (((w ^ k[2]) & k[3]) | k[4]) + k[5];
    c = k[6] >= w;
    dc = k[6][3:0] >= w[3:0];
    w = k[6] - w;
    z = (w == 8'h00);
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    bus(1'b1, 1'b0, REG_CTRL, 32'h0000_0003, 32'h0);
    bus(1'b0, 1'b1, REG_CTRL, 32'h0, 32'h0000_0003);
    bus(1'b0, 1'b1, 8'h7c, 32'h0, 32'h0);
    bus(1'b0, 1'b0, 8'h00, 32'h0, 32'h0);
    for (int i = 0; i < 600 && sleepSeen !== 1'b1; i++) begin
      @(posedge ref_clk);
    end
    if (sleepSeen !== 1'b1) begin
      failCount++;
      testDone();
    end
    // read-only places must ignore these writes
    bus(1'b1, 1'b0, REG_STAT, 32'hffff_ffff, 32'h0);
    bus(1'b1, 1'b0, REG_WREG, 32'h0000_0000, 32'h0);
    bus(1'b0, 1'b1, REG_STAT, 32'h0, {26'h0, 3'b110, z, dc, c});
    bus(1'b0, 1'b1, REG_WREG, 32'h0, {24'h0, k[7]});
    bus(1'b0, 1'b0, 8'h00, 32'h0, 32'h0);
    repeat (8) @(posedge ref_clk);
    check(32'(wq.size()), 32'd0);
    check(32'(rq.size()), 32'd0);
    check(32'(wdCount), 32'd1);
    check(32'(mmCount), 32'd1);
    check(32'(psCount), 32'd1);
    testDone();
  end
endmodule : mcu_instruction_decode_rmw_tb
